// File: ov_fault_ctrl.sv
// Input overvoltage fault control with its command registers and link port
//
// Contract
// - Threshold is a two-byte read-write Linear-11 value.
// - Threshold resets to the 15.5 volt encoding.
// - Threshold and response are single global copies.
// - Response resets to disable with no retry.
// - Fault drives alert low and sets status.
// - Fault status clears only by clear-faults command.
// - Mode 10 disables, then follows retry setting.
// - Mode 11 off until input falls below warning limit.
// - Retry 000 stays off until restart.
// - Retry 111 restarts forever, spaced by delay.
// - Retrying stops on off command, bias, fault.
// - Retry delay is (field plus one) times 35ms.
// - Warning limit resets to the 14.5 volt encoding.
`default_nettype none

module ov_fault_ctrl
   import ov_fault_pkg::*;
#(
   parameter int RETRY_CYCLES = ov_fault_pkg::RETRY_UNIT_CYCLES  // Cycles per retry step
)
(
   input  wire logic        clk,                  // Core clock, 40 MHz
   input  wire logic        rst_b,                // Core reset, sync, active low
   input  wire logic        link_clk,             // Management link clock
   input  wire logic        link_rst_b,           // Link reset, sync, active low
   input  wire logic        lk_req_valid,         // Command offered on link
   input  wire logic        lk_req_write,         // High for write, low for read
   input  wire logic [7:0]  lk_req_code,          // Command code
   input  wire logic [15:0] lk_req_data,          // Write data
   output logic             lk_busy,              // Command in flight
   output logic             lk_rsp_valid,         // Pulse: answer ready
   output logic [15:0]      lk_rsp_data,          // Read data
   output logic             lk_rsp_error,         // Unknown command code
   input  wire logic [15:0] vin_sample,           // Input voltage, Linear-11
   input  wire logic        run_request,          // Output commanded on
   input  wire logic        bias_ok,              // Bias power present
   input  wire logic        other_fault,          // Another fault forces shutdown
   output logic             output_enable,        // Power stage enable
   output logic             alert_output_line_b,  // Alert line, active low
   output logic             ov_fault_status       // Latched fault status
);

   // =========================================================
   // Link domain storage
   logic        pending_ff;       // Command waiting for core
   logic        req_tgl_ff;       // Flips once per command
   logic        wr_hold_ff;       // Held write flag
   logic [7:0]  code_hold_ff;     // Held command code
   logic [15:0] data_hold_ff;     // Held write data
   logic        ack_s;            // Synchronised core acknowledge
   logic        ack_d_ff;         // Previous acknowledge level
   logic        ack_edge;         // Core finished a command
   logic        rsp_valid_ff;     // Answer pulse
   logic [15:0] rsp_data_ff;      // Answer data
   logic        rsp_error_ff;     // Answer error flag

   // =========================================================
   // Core domain storage
   logic        req_s;            // Synchronised request toggle
   logic        req_d_ff;         // Previous request level
   logic        req_edge;         // New command arrived
   logic        ack_tgl_ff;       // Flips once per finished command
   logic [15:0] rd_data_ff;       // Read result for the link
   logic        rd_error_ff;      // Error result for the link
   logic [15:0] thr_ff;           // Overvoltage threshold
   logic [7:0]  rsp_ff;           // Response configuration
   logic [15:0] warn_ff;          // Warning limit
   logic        sts_ff;           // Latched fault status
   logic        clear_fire;       // Clear-faults command executes
   logic        ov_now;           // Sample above threshold
   logic        below_warn;       // Sample below warning limit
   logic        run_ok;           // Running is allowed
   logic        trip;             // Fault seen while running
   logic        retry_forever;    // Response selects endless retry
   logic        timer_start;      // Load retry timer
   logic        timer_done;       // Retry delay over
   ctl_state_t  state_ff;         // Output control state
   ctl_state_t  nxt_state;        // Next control state

   // =========================================================
   // Link side: take a command and hold it until answered
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_b)
      begin
         pending_ff   <= 1'b0;
         req_tgl_ff   <= 1'b0;
         wr_hold_ff   <= 1'b0;
         code_hold_ff <= 8'h00;
         data_hold_ff <= 16'h0000;
      end
      else if (lk_req_valid && !pending_ff)
      begin
         // Fields stay still while the core samples them
         pending_ff   <= 1'b1;
         req_tgl_ff   <= ~req_tgl_ff;
         wr_hold_ff   <= lk_req_write;
         code_hold_ff <= lk_req_code;
         data_hold_ff <= lk_req_data;
      end
      else if (ack_edge)
      begin
         pending_ff <= 1'b0;
      end
   end

   // Acknowledge from core
   sync_bit u_ack_sync
   (
      .clk      (link_clk),
      .rst_b    (link_rst_b),
      .async_in (ack_tgl_ff),
      .sync_out (ack_s)
   );

   assign ack_edge = ack_s ^ ack_d_ff;
   assign lk_busy  = pending_ff;

   // =========================================================
   // Link side: capture the answer
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_b)
      begin
         ack_d_ff     <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_data_ff  <= 16'h0000;
         rsp_error_ff <= 1'b0;
      end
      else
      begin
         ack_d_ff     <= ack_s;
         rsp_valid_ff <= ack_edge;
         if (ack_edge)
         begin
            // Core result is stable until the next command
            rsp_data_ff  <= rd_data_ff;
            rsp_error_ff <= rd_error_ff;
         end
      end
   end

   assign lk_rsp_valid = rsp_valid_ff;
   assign lk_rsp_data  = rsp_data_ff;
   assign lk_rsp_error = rsp_error_ff;

   // =========================================================
   // Core side: notice a new command
   sync_bit u_req_sync
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (req_tgl_ff),
      .sync_out (req_s)
   );

   assign req_edge   = req_s ^ req_d_ff;
   assign clear_fire = req_edge && wr_hold_ff && (code_hold_ff == CMD_CLEAR_FAULTS);

   // =========================================================
   // Core side: single global register set
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         thr_ff  <= THR_RESET;
         rsp_ff  <= RSP_RESET;
         warn_ff <= WARN_RESET;
      end
      else if (req_edge && wr_hold_ff)
      begin
         // One copy shared by every output page
         unique case (code_hold_ff)
            CMD_OV_THRESHOLD: thr_ff  <= data_hold_ff;
            CMD_OV_RESPONSE:  rsp_ff  <= data_hold_ff[7:0];
            CMD_OV_WARN:      warn_ff <= data_hold_ff;
            default:          thr_ff  <= thr_ff;
         endcase
      end
   end

   // =========================================================
   // Core side: read data, error and acknowledge
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         req_d_ff    <= 1'b0;
         ack_tgl_ff  <= 1'b0;
         rd_data_ff  <= 16'h0000;
         rd_error_ff <= 1'b0;
      end
      else
      begin
         req_d_ff <= req_s;
         if (req_edge)
         begin
            ack_tgl_ff  <= ~ack_tgl_ff;
            rd_error_ff <= 1'b0;
            unique case (code_hold_ff)
               CMD_OV_THRESHOLD: rd_data_ff <= thr_ff;
               CMD_OV_RESPONSE:  rd_data_ff <= {8'h00, rsp_ff};
               CMD_OV_WARN:      rd_data_ff <= warn_ff;
               CMD_STATUS_INPUT: rd_data_ff <= 16'(sts_ff) << STS_OV_FAULT;
               CMD_CLEAR_FAULTS: rd_data_ff <= 16'h0000;
               default:
               begin
                  rd_data_ff  <= 16'h0000;
                  rd_error_ff <= 1'b1;
               end
            endcase
         end
      end
   end

   // =========================================================
   // Fault detection against the programmed limits
   assign ov_now        = l11_to_fixed(vin_sample) > l11_to_fixed(thr_ff);
   assign below_warn    = l11_to_fixed(vin_sample) < l11_to_fixed(warn_ff);
   assign run_ok        = run_request && bias_ok && !other_fault;
   assign trip          = (state_ff == ST_RUN) && run_ok && ov_now;
   assign retry_forever = (rsp_ff[RSP_MODE_MSB:RSP_MODE_LSB] == MODE_DISABLE_RETRY)
                          && (rsp_ff[RSP_RETRY_MSB:RSP_RETRY_LSB] == RETRY_FOREVER);

   // =========================================================
   // Latched fault status; a new fault wins over a clear
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sts_ff <= 1'b0;
      end
      else if (trip)
      begin
         sts_ff <= 1'b1;
      end
      else if (clear_fire)
      begin
         sts_ff <= 1'b0;
      end
   end

   assign ov_fault_status     = sts_ff;
   assign alert_output_line_b = !sts_ff;

   // =========================================================
   // Output control next state
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OFF:
         begin
            if (run_ok)
               nxt_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (!run_ok)
               nxt_state = ST_OFF;
            else if (ov_now)
            begin
               if (rsp_ff[RSP_MODE_MSB:RSP_MODE_LSB] == MODE_WHILE_FAULT)
                  nxt_state = ST_HOLD;
               else if (retry_forever)
                  nxt_state = ST_WAIT;
               else
                  nxt_state = ST_LATCHED;
            end
         end
         ST_WAIT:
         begin
            if (!run_ok)
               nxt_state = ST_OFF;
            else if (timer_done)
               nxt_state = ST_RUN;
         end
         ST_HOLD:
         begin
            if (!run_ok)
               nxt_state = ST_OFF;
            else if (below_warn)
               nxt_state = ST_RUN;
         end
         ST_LATCHED:
         begin
            // Only a fresh on command or lost bias restarts
            if (!run_request || !bias_ok)
               nxt_state = ST_OFF;
         end
         default:
         begin
            nxt_state = ST_OFF;
         end
      endcase
   end

   // =========================================================
   // Output control state and enable
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_ff      <= ST_OFF;
         output_enable <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         output_enable <= (nxt_state == ST_RUN);
      end
   end

   assign timer_start = trip && retry_forever;

   // Retry spacing between restart attempts
   retry_timer #(.UNIT_CYCLES (RETRY_CYCLES)) u_retry
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (timer_start),
      .abort   (!run_ok),
      .delay   (rsp_ff[RSP_DELAY_MSB:0]),
      .running (),
      .done    (timer_done)
   );

   // =========================================================
   // Checks
   a_thr_reset_val: assert property (@(posedge clk)
      $rose(rst_b) |-> thr_ff == THR_RESET && warn_ff == WARN_RESET)
      else $error("Limit reset values wrong");

   a_rsp_reset_val: assert property (@(posedge clk)
      $rose(rst_b) |-> rsp_ff == RSP_RESET && state_ff == ST_OFF)
      else $error("Response reset value wrong");

   a_trip_alert: assert property (@(posedge clk) disable iff (!rst_b)
      trip |=> !alert_output_line_b && ov_fault_status && !output_enable)
      else $error("Fault did not raise alert");

   a_sts_sticky: assert property (@(posedge clk) disable iff (!rst_b)
      sts_ff && !clear_fire |=> sts_ff)
      else $error("Fault status cleared without command");

   a_hold_off: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == ST_HOLD && ov_now |=> !output_enable)
      else $error("Output on during held fault");

   a_latched_stays: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == ST_LATCHED && run_request && bias_ok
      |=> state_ff == ST_LATCHED && !output_enable)
      else $error("Latched fault restarted");

   a_retry_resume: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == ST_WAIT && timer_done && run_ok |=> state_ff == ST_RUN ##0 output_enable)
      else $error("Retry attempt missed");

   a_retry_stop: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == ST_WAIT && !run_ok |=> state_ff == ST_OFF && !output_enable && !timer_done)
      else $error("Retry continued after stop");

   a_unused_code: assert property (@(posedge clk) disable iff (!rst_b)
      trip && !retry_forever
      && rsp_ff[RSP_MODE_MSB:RSP_MODE_LSB] != MODE_WHILE_FAULT |=> state_ff == ST_LATCHED)
      else $error("Unused response not treated as no retry");

   a_link_busy: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      lk_req_valid && !lk_busy |=> lk_busy && !lk_rsp_valid)
      else $error("Link did not hold command");

endmodule

`default_nettype wire

// File: ov_fault_pkg.sv
// Shared constants, types and helpers for the input overvoltage fault block
`default_nettype none

package ov_fault_pkg;

   // =========================================================
   // Command codes on the management link
   localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;   // Clears latched fault status
   localparam logic [7:0]  CMD_OV_THRESHOLD = 8'h55;   // Overvoltage fault threshold
   localparam logic [7:0]  CMD_OV_RESPONSE  = 8'h56;   // Overvoltage fault response
   localparam logic [7:0]  CMD_OV_WARN      = 8'h57;   // Overvoltage warning limit
   localparam logic [7:0]  CMD_STATUS_INPUT = 8'h7c;   // Input status byte

   // =========================================================
   // Reset values
   localparam logic [15:0] THR_RESET  = 16'hd3e0;      // 15.5 V in Linear-11
   localparam logic [15:0] WARN_RESET = 16'hd3a0;      // 14.5 V in Linear-11
   localparam logic [7:0]  RSP_RESET  = 8'h80;         // Disable, no retry

   // =========================================================
   // Field positions
   localparam int          L11_EXP_MSB   = 15;         // Signed exponent N
   localparam int          L11_EXP_LSB   = 11;
   localparam int          L11_MANT_MSB  = 10;         // Signed mantissa Y
   localparam int          RSP_MODE_MSB  = 7;          // Response mode
   localparam int          RSP_MODE_LSB  = 6;
   localparam int          RSP_RETRY_MSB = 5;          // Retry setting
   localparam int          RSP_RETRY_LSB = 3;
   localparam int          RSP_DELAY_MSB = 2;          // Retry delay
   localparam int          STS_OV_FAULT  = 7;          // Fault bit in status byte
   localparam int          L11_EXP_BIAS  = 16;         // Shifts N into 0..31

   // =========================================================
   // Field encodings
   localparam logic [1:0]  MODE_DISABLE_RETRY = 2'b10;  // Disable then retry setting
   localparam logic [1:0]  MODE_WHILE_FAULT   = 2'b11;  // Off until input falls below warning limit
   localparam logic [2:0]  RETRY_NONE         = 3'b000; // Stay off until restart
   localparam logic [2:0]  RETRY_FOREVER      = 3'b111; // Retry continuously

   // =========================================================
   // Timing
   localparam int          CLK_HZ            = 40_000_000;  // Core clock rate
   localparam int          RETRY_UNIT_MS     = 35;          // Retry delay step
   localparam int          RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);

   // =========================================================
   // Output control states, Gray coded along the usual path
   typedef enum logic [2:0]
   {
      ST_OFF     = 3'b000,                             // Output commanded off
      ST_RUN     = 3'b001,                             // Output enabled
      ST_WAIT    = 3'b011,                             // Waiting out retry delay
      ST_HOLD    = 3'b010,                             // Off until input falls below warning limit
      ST_LATCHED = 3'b110                              // Off until restart
   } ctl_state_t;

   // =========================================================
   // Linear-11 word to fixed point, value scaled by 2^16
   function automatic logic signed [47:0] l11_to_fixed(input logic [15:0] word);
      logic signed [47:0] mant;
      logic        [5:0]  shift;
      mant  = {{37{word[L11_MANT_MSB]}}, word[L11_MANT_MSB:0]};
      shift = 6'(int'($signed(word[L11_EXP_MSB:L11_EXP_LSB])) + L11_EXP_BIAS);
      return mant <<< shift;
   endfunction

endpackage

`default_nettype wire

// File: sync_bit.sv
// Two flip-flop synchroniser for one level or toggle
`default_nettype none

module sync_bit
(
   input  wire logic clk,       // Destination clock
   input  wire logic rst_b,     // Synchronous reset, active low
   input  wire logic async_in,  // Level from another domain
   output logic      sync_out   // Level safe to read
);

   logic meta_ff;               // First stage, read only by second

   // =========================================================
   // Two stage capture
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         meta_ff  <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

`default_nettype wire

// File: retry_timer.sv
// Retry delay timer counting whole retry steps
`default_nettype none

module retry_timer
   import ov_fault_pkg::*;
#(
   parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES  // Cycles in one retry step
)
(
   input  wire logic       clk,       // Core clock
   input  wire logic       rst_b,     // Synchronous reset, active low
   input  wire logic       start,     // Pulse: begin a delay
   input  wire logic       abort,     // Level: cancel a running delay
   input  wire logic [2:0] delay,     // Step count minus one
   output logic            running,   // Delay in progress
   output logic            done       // Pulse on the last delay cycle
);

   localparam int CW = $clog2(UNIT_CYCLES + 1);

   logic [CW-1:0] unit_cnt_ff;        // Cycles left in this step
   logic [2:0]    steps_left_ff;      // Steps left after this one
   logic          running_ff;         // Delay active
   int            elapsed_ff;         // Cycles spent, for checking
   logic [2:0]    delay_seen_ff;      // Delay captured, for checking

   assign running = running_ff;
   assign done    = running_ff && (unit_cnt_ff == '0) && (steps_left_ff == 3'h0);

   // =========================================================
   // Step counter, (delay + 1) steps of UNIT_CYCLES each
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         unit_cnt_ff   <= '0;
         steps_left_ff <= 3'h0;
         running_ff    <= 1'b0;
      end
      else if (start)
      begin
         unit_cnt_ff   <= CW'(UNIT_CYCLES - 1);
         steps_left_ff <= delay;
         running_ff    <= 1'b1;
      end
      else if (abort || done)
      begin
         running_ff <= 1'b0;
      end
      else if (running_ff)
      begin
         if (unit_cnt_ff == '0)
         begin
            unit_cnt_ff   <= CW'(UNIT_CYCLES - 1);
            steps_left_ff <= steps_left_ff - 3'h1;
         end
         else
         begin
            unit_cnt_ff <= unit_cnt_ff - CW'(1);
         end
      end
   end

   // =========================================================
   // Helper for the length check
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         elapsed_ff    <= 0;
         delay_seen_ff <= 3'h0;
      end
      else if (start)
      begin
         elapsed_ff    <= 1;
         delay_seen_ff <= delay;
      end
      else if (running_ff)
      begin
         elapsed_ff <= elapsed_ff + 1;
      end
   end

   a_delay_length: assert property (@(posedge clk) disable iff (!rst_b)
      done |-> elapsed_ff == (int'(delay_seen_ff) + 1) * UNIT_CYCLES)
      else $error("Retry delay length wrong");

endmodule

`default_nettype wire

// File: ov_host.sv
// Host controller model that drives commands onto the management link
`default_nettype none

module ov_host
(
   input  wire logic        link_clk,      // Link clock
   input  wire logic        lk_busy,       // Command in flight
   input  wire logic        lk_rsp_valid,  // Answer ready
   input  wire logic [15:0] lk_rsp_data,   // Read data
   output var logic         lk_req_valid,  // Command offered
   output var logic         lk_req_write,  // Write when high
   output var logic  [7:0]  lk_req_code,   // Command code
   output var logic  [15:0] lk_req_data    // Write data
);
   timeunit 1ns;
   timeprecision 1ps;

   // =========================================================
   // Idle link at time zero
   initial
   begin
      lk_req_valid = 1'b0;
      lk_req_write = 1'b0;
      lk_req_code  = 8'h00;
      lk_req_data  = 16'h0000;
   end

   // Offer one command, hold it until the answer, then release
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge link_clk);
      #1;
      // Offer only while the block is free to take it
      while (lk_busy !== 1'b0)
      begin
         @(posedge link_clk);
         #1;
      end
      lk_req_valid = 1'b1;
      lk_req_write = w;
      lk_req_code  = c;
      lk_req_data  = d;
      do
      begin
         @(posedge link_clk);
         #1;
      end
      while (lk_rsp_valid !== 1'b1);
      q = lk_rsp_data;
      lk_req_valid = 1'b0;
      // Released data must not keep its last value
      lk_req_data = ~d;
   endtask
endmodule

`default_nettype wire

// File: ov_fault_ctrl_tb.sv
// Self-checking bench for the input overvoltage fault control
`default_nettype none

module ov_fault_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ov_fault_pkg::*;

   // =========================================================
   // Signals
   localparam int RC = 20;  // Shortened retry step
   logic        clk = 0, link_clk = 0, rst_b = 0, link_rst_b = 0;
   logic        run_request = 0, bias_ok = 1, other_fault = 0;
   logic [15:0] vin_sample = 16'hd200;
   logic        lk_req_valid, lk_req_write, lk_busy, lk_rsp_valid, lk_rsp_error;
   logic [7:0]  lk_req_code;
   logic [15:0] lk_req_data, lk_rsp_data;
   logic        output_enable, alert_output_line_b, ov_fault_status;
   int          n_fail = 0, checked = 0, cycles = 0, n;
   logic [15:0] lat [2] = '{16'h0080, 16'h0040};

   always #12.5 clk = ~clk;
   always #16 link_clk = ~link_clk;

   ov_fault_ctrl #(.RETRY_CYCLES(RC)) DUT (.clk, .rst_b, .link_clk, .link_rst_b,
      .lk_req_valid, .lk_req_write, .lk_req_code, .lk_req_data, .lk_busy, .lk_rsp_valid,
      .lk_rsp_data, .lk_rsp_error, .vin_sample, .run_request, .bias_ok, .other_fault,
      .output_enable, .alert_output_line_b, .ov_fault_status);
   ov_host u_host (.link_clk, .lk_busy, .lk_rsp_valid, .lk_rsp_data, .lk_req_valid,
      .lk_req_write, .lk_req_code, .lk_req_data);

   // =========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] q;
      u_host.xfer(1'b0, c, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      logic [15:0] q;
      u_host.xfer(1'b1, c, d, q);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic drv(input logic r, input logic [15:0] v, input int k);
      @(posedge clk);
      run_request <= r;
      vin_sample <= v;
      cyc(k);
   endtask
   // Enable, alert, status in that order
   task automatic pins(input logic [2:0] e);
      chk({13'h0000, output_enable, alert_output_line_b, ov_fault_status}, {13'h0000, e});
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         close_out();
      end
   end

   // =========================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      link_rst_b <= 1'b1;
      rd(8'h55, 16'hd3e0);
      rd(8'h56, 16'h0080);
      rd(8'h57, 16'hd3a0);
      wr(8'h55, 16'hd3c0);
      rd(8'h55, 16'hd3c0);
      chk({15'h0000, lk_rsp_error}, 16'h0000);
      rd(8'h99, 16'h0000);
      chk({15'h0000, lk_rsp_error}, 16'h0001);
      $display("test registers done");
      foreach (lat[i])
      begin
         wr(8'h56, lat[i]);
         drv(1'b1, 16'hd200, 4);
         pins(3'b110);
         drv(1'b1, 16'hd3f0, 4);
         pins(3'b001);
         drv(1'b1, 16'hd200, 6);
         pins(3'b001);
         rd(8'h7c, 16'h0080);
         wr(8'h03, 16'h0000);
         rd(8'h7c, 16'h0000);
         drv(1'b0, 16'hd200, 3);
      end
      $display("test latched done");
      wr(8'h56, 16'h00c0);
      drv(1'b1, 16'hd200, 4);
      drv(1'b1, 16'hd3f0, 4);
      drv(1'b1, 16'hd3b0, 6);
      pins(3'b001);
      drv(1'b1, 16'hd200, 4);
      pins(3'b101);
      wr(8'h03, 16'h0000);
      $display("test hold done");
      wr(8'h56, 16'h00b9);
      drv(1'b1, 16'hd3f0, 1);
      for (int j = 0; j < 2; j++)
      begin
         n = 0;
         while (output_enable === 1'b1 && n < 300)
         begin
            cyc(1);
            n++;
         end
         n = 0;
         while (output_enable !== 1'b1 && n < 300)
         begin
            cyc(1);
            n++;
         end
         chk(16'(n >= 2 * RC - 1 && n <= 2 * RC + 1), 16'h0001);
      end
      @(posedge clk);
      other_fault <= 1'b1;
      cyc(5 * RC);
      pins(3'b001);
      $display("test retry done");
      close_out();
   end
endmodule

`default_nettype wire
